/* hdl/iobp_defs.vh */
`ifndef IOBP_DEFS_VH
`define IOBP_DEFS_VH
// Word width of the I/O exchange
`define IOBP_WORD_W 24
// Least spacing between two transfer-done strobes, in clocks
`define IOBP_DONE_GAP_CLKS 8
// Least spacing from a transfer-done strobe to a command strobe, in clocks
`define IOBP_DONE_CMD_CLKS 4
// Spacing counter width and its saturation value
`define IOBP_SPC_W 4
`define IOBP_SPC_MAX 4'hF
// Microinstruction kinds presented with an access
`define IOBP_OP_REGMOVE 2'h0
`define IOBP_OP_PADMOVE 2'h1
`define IOBP_OP_SHIFT 2'h2
`define IOBP_OP_NONE 2'h3
// Pseudoregister selects
`define IOBP_SEL_DATA 2'h0
`define IOBP_SEL_CMD 2'h1
`define IOBP_SEL_SWITCH 2'h2
`define IOBP_SEL_NULL 2'h3
`endif

/* hdl/iobp_spreader.v */
`timescale 1ns/1ps
`default_nettype none
`include "iobp_defs.vh"
module iobp_spreader #(
  parameter DONE_GAP = `IOBP_DONE_GAP_CLKS,
  parameter CMD_GAP = `IOBP_DONE_CMD_CLKS
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Strobe issued this cycle
  input wire done_fire,
  // Permissions for the next strobe
  output wire done_ok,
  output wire cmd_ok
);
  // Clocks since the last transfer-done strobe, saturating
  reg [`IOBP_SPC_W-1:0] since_ff;
  reg [`IOBP_SPC_W-1:0] nxt_since;

  // Restart at one on a strobe, so count equals edges elapsed
  always @* begin
    nxt_since = since_ff;
    if (done_fire) begin
      nxt_since = 4'h1;
    end else if (since_ff != `IOBP_SPC_MAX) begin
      nxt_since = since_ff + 4'h1;
    end
  end

  // Reset to saturated so the first access is not held off
  always @(posedge mclk) begin
    if (rst) begin
      since_ff <= `IOBP_SPC_MAX;
    end else begin
      since_ff <= nxt_since;
    end
  end

  assign done_ok = (since_ff >= DONE_GAP[`IOBP_SPC_W-1:0]);
  assign cmd_ok = (since_ff >= CMD_GAP[`IOBP_SPC_W-1:0]);
endmodule
`default_nettype wire

/* hdl/iobp_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "iobp_defs.vh"
// Contract
// - Data read strobes done, captures bus word
// - Data write strobes done, drives source word
// - Shift micro may only write data
// - Done strobes at least 8 clocks apart
// - Console load on data strobes done
// - Command port is write-only, 24 bits
// - Command write strobes valid, drives word
// - All three micros may write command
// - Command strobe 4 clocks after done
// - Reading command port does nothing
// - Console load on command sends switches
// - Switch register read-only, returns switches; read while a micro data read strobe is high, it returns the bus word
module iobp_port #(
  parameter W = `IOBP_WORD_W
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Microinstruction access request
  input wire acc_req,
  input wire acc_wr,
  input wire [1:0] acc_op,
  input wire [1:0] acc_sel,
  input wire [W-1:0] acc_wdata,
  // Answer to the request
  output reg acc_busy_ff,
  output reg acc_done_ff,
  output reg [W-1:0] acc_rdata_ff,
  // Console
  input wire con_load,
  input wire [1:0] con_sel,
  input wire [W-1:0] console_switch_value,
  output reg [W-1:0] con_lamps_ff,
  // I/O bus
  input wire [W-1:0] io_bus_in,
  output reg [W-1:0] io_bus_out_ff,
  output reg io_bus_oe_ff,
  output reg transfer_done_strobe_ff,
  output reg command_valid_strobe_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;

  // Pending access held while the spacing logic stalls it
  reg [1:0] st_ff;
  reg pend_wr_ff;
  reg pend_con_ff;
  reg [1:0] pend_sel_ff;
  reg [W-1:0] pend_word_ff;
  // Spacing permissions
  wire done_ok;
  wire cmd_ok;
  // Strobe firing this cycle
  reg fire_done;
  reg fire_cmd;

  iobp_spreader u_spread (
    .mclk(mclk),
    .rst(rst),
    .done_fire(fire_done),
    .done_ok(done_ok),
    .cmd_ok(cmd_ok)
  );

  // Legality of a microinstruction access
  function legal;
    input wr;
    input [1:0] op;
    input [1:0] sel;
    begin
      legal = 1'b0;
      if (op != `IOBP_OP_NONE) begin
        if (sel == `IOBP_SEL_DATA) begin
          legal = wr | (op != `IOBP_OP_SHIFT);
        end else if (sel == `IOBP_SEL_CMD) begin
          legal = wr;
        end else if (sel == `IOBP_SEL_SWITCH) begin
          legal = ~wr;
        end
      end
    end
  endfunction

  // Whether the pending access may strobe this cycle
  always @* begin
    fire_done = 1'b0;
    fire_cmd = 1'b0;
    if (st_ff == ST_WAIT) begin
      if (pend_sel_ff == `IOBP_SEL_DATA) begin
        fire_done = done_ok;
      end else begin
        fire_cmd = cmd_ok;
      end
    end
  end

  // Accept, stall and complete accesses
  always @(posedge mclk) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      pend_wr_ff <= 1'b0;
      pend_con_ff <= 1'b0;
      pend_sel_ff <= `IOBP_SEL_NULL;
      pend_word_ff <= {W{1'b0}};
      acc_busy_ff <= 1'b0;
      acc_done_ff <= 1'b0;
      acc_rdata_ff <= {W{1'b0}};
      con_lamps_ff <= {W{1'b0}};
      io_bus_out_ff <= {W{1'b0}};
      io_bus_oe_ff <= 1'b0;
      transfer_done_strobe_ff <= 1'b0;
      command_valid_strobe_ff <= 1'b0;
    end else begin
      // Strobes are one-clock pulses by default
      transfer_done_strobe_ff <= 1'b0;
      command_valid_strobe_ff <= 1'b0;
      io_bus_oe_ff <= 1'b0;
      acc_done_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          // Console load takes priority; it is a manual action while halted
          if (con_load && con_sel == `IOBP_SEL_DATA) begin
            st_ff <= ST_WAIT;
            pend_wr_ff <= 1'b0;
            pend_con_ff <= 1'b1;
            pend_sel_ff <= `IOBP_SEL_DATA;
            acc_busy_ff <= 1'b1;
          end else if (con_load && con_sel == `IOBP_SEL_CMD) begin
            st_ff <= ST_WAIT;
            pend_wr_ff <= 1'b1;
            pend_con_ff <= 1'b1;
            pend_sel_ff <= `IOBP_SEL_CMD;
            pend_word_ff <= console_switch_value;
            acc_busy_ff <= 1'b1;
          end else if (con_load && con_sel == `IOBP_SEL_SWITCH) begin
            con_lamps_ff <= console_switch_value;
          end else if (acc_req) begin
            if (legal(acc_wr, acc_op, acc_sel) && acc_sel != `IOBP_SEL_SWITCH) begin
              st_ff <= ST_WAIT;
              pend_wr_ff <= acc_wr;
              pend_con_ff <= 1'b0;
              pend_sel_ff <= acc_sel;
              pend_word_ff <= acc_wdata;
              acc_busy_ff <= 1'b1;
            end else begin
              // Switch read answers at once; illegal or command read is a no-op
              acc_done_ff <= 1'b1;
              if (legal(acc_wr, acc_op, acc_sel)) begin
                acc_rdata_ff <= console_switch_value;
              end
            end
          end
        end
        ST_WAIT: begin
          if (fire_done) begin
            // Data word travels with the done strobe in the same cycle
            transfer_done_strobe_ff <= 1'b1;
            io_bus_oe_ff <= pend_wr_ff;
            io_bus_out_ff <= pend_word_ff;
            st_ff <= ST_IDLE;
            acc_busy_ff <= 1'b0;
            acc_done_ff <= ~pend_con_ff;
          end else if (fire_cmd) begin
            command_valid_strobe_ff <= 1'b1;
            io_bus_oe_ff <= 1'b1;
            io_bus_out_ff <= pend_word_ff;
            st_ff <= ST_IDLE;
            acc_busy_ff <= 1'b0;
            acc_done_ff <= ~pend_con_ff;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
          acc_busy_ff <= 1'b0;
        end
      endcase
      // Capture the bus word one edge after a read strobe, while partner holds it
      if (transfer_done_strobe_ff && !io_bus_oe_ff) begin
        if (pend_con_ff) begin
          con_lamps_ff <= io_bus_in;
        end else begin
          acc_rdata_ff <= io_bus_in;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/iobp_props.sv */
`timescale 1ns/1ps
`default_nettype none
module iobp_props (
  // Clock, reset and requests
  input wire mclk, rst, acc_req, acc_wr, con_load,
  input wire [1:0] acc_op, acc_sel, con_sel,
  // Answers and strobes
  input wire acc_busy_ff, acc_done_ff, io_bus_oe_ff, transfer_done_strobe_ff, command_valid_strobe_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire td = transfer_done_strobe_ff; // Done strobe
  wire cv = command_valid_strobe_ff; // Command strobe
  // Micro access taken at this edge, by select; op none never strobes
  sequence s_acc(s);
    acc_req && !acc_busy_ff && !con_load && acc_sel == s && acc_op != 2'h3;
  endsequence
  a_done_gap: assert property (td |=> !td [*7]) else $error("done gap");
  a_cmd_gap: assert property (td |=> !cv [*3]) else $error("command gap");
  a_oe_strobe: assert property (io_bus_oe_ff |-> td || cv) else $error("stray drive");
  a_data_wr: assert property (s_acc(2'h0) ##0 acc_wr |-> ##[1:8] (td && io_bus_oe_ff))
    else $error("data write");
  a_data_rd: assert property (s_acc(2'h0) ##0 (!acc_wr && acc_op != 2'h2) |-> ##[1:8] (td && !io_bus_oe_ff))
    else $error("data read");
  a_shift_rd: assert property (s_acc(2'h0) ##0 (!acc_wr && acc_op == 2'h2) |=> acc_done_ff && !td)
    else $error("shift read");
  a_cmd_wr: assert property (s_acc(2'h1) ##0 acc_wr |-> ##[1:8] (cv && io_bus_oe_ff))
    else $error("command write");
  a_cmd_rd: assert property (s_acc(2'h1) ##0 !acc_wr |=> acc_done_ff && !cv) else $error("command read");
  a_con_cmd: assert property (con_load && !acc_busy_ff && con_sel == 2'h1 |-> ##[1:8] cv)
    else $error("console command");
endmodule
bind iobp_port iobp_props u_props (.mclk(mclk), .rst(rst), .acc_req(acc_req), .acc_wr(acc_wr), .con_load(con_load),
  .acc_op(acc_op), .acc_sel(acc_sel), .con_sel(con_sel), .acc_busy_ff(acc_busy_ff), .acc_done_ff(acc_done_ff),
  .io_bus_oe_ff(io_bus_oe_ff), .transfer_done_strobe_ff(transfer_done_strobe_ff),
  .command_valid_strobe_ff(command_valid_strobe_ff));
`default_nettype wire

/* test/iobp_ioctl.sv */
`timescale 1ns/1ps
`default_nettype none
module iobp_ioctl (
  // Clock, reset, strobes and word from the port
  input wire mclk, rst, td, cv, oe,
  input wire [23:0] bo,
  // Word handed back on a read
  input wire [23:0] rsp,
  // Returned lines and last word taken
  output wire [23:0] bi,
  output reg [23:0] cap_ff
);
  reg [23:0] last_ff; // Previous level of returned lines
  // Valid only inside a read strobe; elsewhere the lines flip so a late sample shows
  assign bi = (td && !oe) ? rsp : ~last_ff;
  // Take the driven word while a strobe is high
  always @(posedge mclk) begin
    last_ff <= rst ? 24'h0 : bi;
    if (rst) cap_ff <= 24'h0;
    else if ((td || cv) && oe) cap_ff <= bo;
  end
endmodule
`default_nettype wire

/* test/tb_iobp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_iobp_port;
  // Drives; sw and rsp are switch and returned words
  reg mclk = 1'h0, rst = 1'h1, req = 1'h0, wr = 1'h0, ld = 1'h0;
  reg [1:0] op = 2'h0, sel = 2'h0, cs = 2'h0;
  reg [23:0] wd = 24'h0, sw = 24'hC35A96, rsp = 24'h3CA569;
  wire busy, done, oe, td, cv;
  wire [23:0] rdata, lamps, bo, bi, cap;
  // Rows: wr, op, sel, strobe (1 done, 2 command)
  reg [6:0] rows [0:11];
  integer fails = 0, check_count = 0, cyc = 0, nt = 0, nc = 0, i, n, t0, c0;
  always #5 mclk = ~mclk;
  iobp_port dut (.mclk(mclk), .rst(rst), .acc_req(req), .acc_wr(wr), .acc_op(op), .acc_sel(sel), .acc_wdata(wd),
    .acc_busy_ff(busy), .acc_done_ff(done), .acc_rdata_ff(rdata), .con_load(ld), .con_sel(cs),
    .console_switch_value(sw), .con_lamps_ff(lamps), .io_bus_in(bi), .io_bus_out_ff(bo), .io_bus_oe_ff(oe),
    .transfer_done_strobe_ff(td), .command_valid_strobe_ff(cv));
  iobp_ioctl io (.mclk(mclk), .rst(rst), .td(td), .cv(cv), .oe(oe), .bo(bo), .rsp(rsp), .bi(bi), .cap_ff(cap));
  task chk(input string nm, input [23:0] e, s);
    begin
      check_count++;
      if (e !== s) begin
        fails++;
        $display("mismatch %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // Strobe tallies and run ceiling
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (td === 1'h1) nt <= nt + 1;
    if (cv === 1'h1) nc <= nc + 1;
    if (cyc == 2000) begin
      fails++;
      conclude;
    end
  end
  // Access or console load; console has no done, so it waits out the spacing
  task go(input [6:0] r, input l);
    begin
      t0 = nt;
      c0 = nc;
      @(posedge mclk);
      {wr, op, sel} <= r[6:2];
      cs <= r[3:2];
      wd <= {16'h5A3C, r, 1'h1};
      req <= !l;
      ld <= l;
      @(posedge mclk);
      req <= 1'h0;
      ld <= 1'h0;
      #1;
      for (n = 0; n < 10 && (l || done !== 1'h1); n++) begin
        @(posedge mclk);
        #1;
      end
      @(posedge mclk);
      #1;
      chk("strobe", r[1:0], {nc != c0, nt != t0});
      if (r[6] && r[1:0]) chk("bus word", l ? sw : wd, cap);
      if (!r[6]) chk("read word", r[3:2] == 2'h2 ? sw : rsp, l ? lamps : rdata);
    end
  endtask
  initial begin
    rows = '{7'h41, 7'h51, 7'h61, 7'h46, 7'h56, 7'h66, 7'h01, 7'h11, 7'h20, 7'h04, 7'h08, 7'h48};
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    #1;
    chk("reset", 24'h0, {busy, oe, td, cv, done});
    for (i = 0; i < 12; i++) go(rows[i], 1'h0);
    go(7'h01, 1'h1);
    go(7'h41, 1'h0);
    go(7'h46, 1'h1);
    conclude;
  end
endmodule
`default_nettype wire
